// File: design/wsm_pkg.sv
package wsm_pkg;

  localparam int WSM_SRC_COUNT = 5;
  localparam int WSM_BYTE_W = 8;

  localparam int WSM_IDX_FOUR = 0;
  localparam int WSM_IDX_FIVE = 1;
  localparam int WSM_IDX_SIX = 2;
  localparam int WSM_IDX_SEVEN = 3;
  localparam int WSM_IDX_EIGHT = 4;

  localparam logic [15:0] WAKE_SOURCE_FOUR_ADDR = 16'h7f59;
  localparam logic [15:0] WAKE_SOURCE_FIVE_ADDR = 16'h7f5e;
  localparam logic [15:0] WAKE_SOURCE_SIX_ADDR = 16'h7f63;
  localparam logic [15:0] WAKE_SOURCE_SEVEN_ADDR = 16'h7f64;
  localparam logic [15:0] WAKE_SOURCE_EIGHT_ADDR = 16'h7f55;
  localparam logic [15:0] WAKE_MASK_ONE_ADDR = 16'h7f2c;
  localparam logic [15:0] WAKE_MASK_TWO_ADDR = 16'h7f2d;
  localparam logic [15:0] WAKE_MASK_FOUR_ADDR = 16'h7f5a;
  localparam logic [15:0] WAKE_MASK_FIVE_ADDR = 16'h7f5f;

  localparam logic [7:0] WSM_BYTE_ZERO = 8'h00;
  localparam logic [7:0] WSM_FULL_VALID = 8'hff;
  localparam logic [7:0] WSM_SEVEN_VALID = 8'h07;
  localparam logic [7:0] WSM_MASK_TWO_VALID = 8'h7f;
  localparam logic WSM_IRQ_LOW_IDLE = 1'b1;

  // Bit positions of source register seven.
  localparam int WSM_SEVEN_FAN_ONE_BIT = 0;
  localparam int WSM_SEVEN_FAN_TWO_BIT = 1;
  localparam int WSM_SEVEN_EITHER_EDGE_BIT = 2;

  localparam logic [WSM_SRC_COUNT-1:0][15:0] WSM_SRC_ADDR = {
    WAKE_SOURCE_EIGHT_ADDR, WAKE_SOURCE_SEVEN_ADDR, WAKE_SOURCE_SIX_ADDR,
    WAKE_SOURCE_FIVE_ADDR, WAKE_SOURCE_FOUR_ADDR};
  localparam logic [WSM_SRC_COUNT-1:0][7:0] WSM_SRC_VALID = {
    WSM_FULL_VALID, WSM_SEVEN_VALID, WSM_FULL_VALID, WSM_FULL_VALID, WSM_FULL_VALID};

endpackage

// File: design/wsm_sticky_bank.sv
`timescale 1ns/1ps
module wsm_sticky_bank
  import wsm_pkg::*;
#(
  parameter logic [7:0] VALID_MASK = WSM_FULL_VALID
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] event_in,
  input wire logic clear_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] status_out
);

  typedef struct packed {
    logic [7:0] status;
  } wsm_bank_state_type;

  wsm_bank_state_type state_q;
  wsm_bank_state_type state_d;
  logic [7:0] clear_bits;

  always_comb begin
    clear_bits = clear_in ? wdata_in : WSM_BYTE_ZERO;
    state_d = state_q;
    // An event in the clearing cycle survives because it is ORed in after the clear.
    state_d.status = ((state_q.status & ~clear_bits) | event_in) & VALID_MASK;
    if (srst_in) begin
      state_d.status = WSM_BYTE_ZERO;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state_q <= state_d;
  end

  assign status_out = state_q.status;

endmodule

// File: design/wsm_wakeup_source_mask_bank.sv
`timescale 1ns/1ps
module wsm_wakeup_source_mask_bank
  import wsm_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] core_addr_in,
  input wire logic core_wr_in,
  input wire logic core_rd_in,
  input wire logic [7:0] core_wdata_in,
  input wire logic [7:0] selectable_edge_event_0x_in,
  input wire logic [7:0] selectable_edge_event_1x_in,
  input wire logic [7:0] selectable_edge_event_six_in,
  input wire logic [2:0] source_seven_event_in,
  input wire logic [7:0] pin_wake_in,
  input wire logic [7:0] source_one_pending_in,
  input wire logic [7:0] source_two_pending_in,
  output logic [7:0] core_rdata_out,
  output logic core_ext_irq_one_low_out,
  output logic core_wake_irq_low_out,
  output logic core_ext_irq_two_out,
  output logic core_ext_irq_three_out
);

  typedef struct packed {
    logic [7:0] mask_one;
    logic [7:0] mask_two;
    logic [7:0] mask_four;
    logic [7:0] mask_five;
    logic [7:0] read_data;
    logic irq_one_low;
    logic wake_low;
    logic irq_two;
    logic irq_three;
  } wsm_top_state_type;

  localparam wsm_top_state_type WSM_TOP_RESET = '{
    mask_one: WSM_BYTE_ZERO,
    mask_two: WSM_BYTE_ZERO,
    mask_four: WSM_BYTE_ZERO,
    mask_five: WSM_BYTE_ZERO,
    read_data: WSM_BYTE_ZERO,
    irq_one_low: WSM_IRQ_LOW_IDLE,
    wake_low: WSM_IRQ_LOW_IDLE,
    irq_two: 1'b0,
    irq_three: 1'b0
  };

  wsm_top_state_type state_q;
  wsm_top_state_type state_d;

  logic [WSM_SRC_COUNT-1:0][7:0] src_event;
  logic [WSM_SRC_COUNT-1:0][7:0] src_stat;
  logic [7:0] live_one;
  logic [7:0] live_two;
  logic [7:0] live_four;
  logic [7:0] live_five;
  logic any_live;

  function automatic logic [7:0] unmasked(input logic [7:0] stat, input logic [7:0] mask);
    unmasked = stat & ~mask;
  endfunction

  function automatic logic hit(input logic strobe, input logic [15:0] addr, input logic [15:0] target);
    hit = strobe && (addr == target);
  endfunction

  assign src_event[WSM_IDX_FOUR] = selectable_edge_event_0x_in;
  assign src_event[WSM_IDX_FIVE] = selectable_edge_event_1x_in;
  assign src_event[WSM_IDX_SIX] = selectable_edge_event_six_in;
  assign src_event[WSM_IDX_SEVEN] = {5'h00, source_seven_event_in};
  assign src_event[WSM_IDX_EIGHT] = pin_wake_in;

  for (genvar i = 0; i < WSM_SRC_COUNT; i++) begin : g_src
    wsm_sticky_bank #(
      .VALID_MASK(WSM_SRC_VALID[i])
    ) u_bank (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .event_in(src_event[i]),
      .clear_in(hit(core_wr_in, core_addr_in, WSM_SRC_ADDR[i])),
      .wdata_in(core_wdata_in),
      .status_out(src_stat[i])
    );
  end

  always_comb begin
    live_one = unmasked(source_one_pending_in, state_q.mask_one);
    live_two = unmasked(source_two_pending_in, state_q.mask_two);
    live_four = unmasked(src_stat[WSM_IDX_FOUR], state_q.mask_four);
    live_five = unmasked(src_stat[WSM_IDX_FIVE], state_q.mask_five);
    // Sources six to eight have no mask register here and always contribute.
    any_live = (|live_one) | (|live_two) | (|live_four) | (|live_five)
      | (|src_stat[WSM_IDX_SIX]) | (|src_stat[WSM_IDX_SEVEN]) | (|src_stat[WSM_IDX_EIGHT]);

    state_d = state_q;
    state_d.irq_one_low = ~any_live;
    state_d.wake_low = ~any_live;
    state_d.irq_two = |live_four;
    state_d.irq_three = |live_five;

    if (hit(core_wr_in, core_addr_in, WAKE_MASK_ONE_ADDR)) begin
      state_d.mask_one = core_wdata_in;
    end
    if (hit(core_wr_in, core_addr_in, WAKE_MASK_TWO_ADDR)) begin
      state_d.mask_two = core_wdata_in & WSM_MASK_TWO_VALID;
    end
    if (hit(core_wr_in, core_addr_in, WAKE_MASK_FOUR_ADDR)) begin
      state_d.mask_four = core_wdata_in;
    end
    if (hit(core_wr_in, core_addr_in, WAKE_MASK_FIVE_ADDR)) begin
      state_d.mask_five = core_wdata_in;
    end

    if (core_rd_in) begin
      case (core_addr_in)
        WAKE_SOURCE_FOUR_ADDR: begin
          state_d.read_data = src_stat[WSM_IDX_FOUR];
        end
        WAKE_SOURCE_FIVE_ADDR: begin
          state_d.read_data = src_stat[WSM_IDX_FIVE];
        end
        WAKE_SOURCE_SIX_ADDR: begin
          state_d.read_data = src_stat[WSM_IDX_SIX];
        end
        WAKE_SOURCE_SEVEN_ADDR: begin
          state_d.read_data = src_stat[WSM_IDX_SEVEN];
        end
        WAKE_SOURCE_EIGHT_ADDR: begin
          state_d.read_data = src_stat[WSM_IDX_EIGHT];
        end
        WAKE_MASK_ONE_ADDR: begin
          state_d.read_data = state_q.mask_one;
        end
        WAKE_MASK_TWO_ADDR: begin
          state_d.read_data = state_q.mask_two;
        end
        WAKE_MASK_FOUR_ADDR: begin
          state_d.read_data = state_q.mask_four;
        end
        WAKE_MASK_FIVE_ADDR: begin
          state_d.read_data = state_q.mask_five;
        end
        default: begin
          state_d.read_data = WSM_BYTE_ZERO;
        end
      endcase
    end

    if (srst_in) begin
      state_d = WSM_TOP_RESET;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state_q <= state_d;
  end

  assign core_rdata_out = state_q.read_data;
  assign core_ext_irq_one_low_out = state_q.irq_one_low;
  assign core_wake_irq_low_out = state_q.wake_low;
  assign core_ext_irq_two_out = state_q.irq_two;
  assign core_ext_irq_three_out = state_q.irq_three;

  // Checks on the running design.

  sequence clear_four_bit0_s;
    core_wr_in && core_addr_in == WAKE_SOURCE_FOUR_ADDR && core_wdata_in[0] && !selectable_edge_event_0x_in[0];
  endsequence

  sequence event_during_clear_s;
    core_wr_in && core_addr_in == WAKE_SOURCE_EIGHT_ADDR && core_wdata_in[0] && pin_wake_in[0];
  endsequence

  sequence read_four_s;
    core_rd_in && core_addr_in == WAKE_SOURCE_FOUR_ADDR;
  endsequence

  sequence mask_one_write_s;
    core_wr_in && core_addr_in == WAKE_MASK_ONE_ADDR;
  endsequence

  sequence mask_two_write_s;
    core_wr_in && core_addr_in == WAKE_MASK_TWO_ADDR;
  endsequence

  sequence read_seven_s;
    core_rd_in && core_addr_in == WAKE_SOURCE_SEVEN_ADDR;
  endsequence

  sequence six_write_s;
    core_wr_in && core_addr_in == WAKE_SOURCE_SIX_ADDR;
  endsequence

  // Nothing unmasked is pending in any source register.
  sequence no_pending_s;
    live_one == WSM_BYTE_ZERO && live_two == WSM_BYTE_ZERO
      && live_four == WSM_BYTE_ZERO && live_five == WSM_BYTE_ZERO
      && src_stat[WSM_IDX_SIX] == WSM_BYTE_ZERO && src_stat[WSM_IDX_SEVEN] == WSM_BYTE_ZERO
      && src_stat[WSM_IDX_EIGHT] == WSM_BYTE_ZERO;
  endsequence

  // Events of source five that arrive while their mask bit is set.
  logic [7:0] masked_five_ev;
  assign masked_five_ev = selectable_edge_event_1x_in & state_q.mask_five;

  w1c_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    clear_four_bit0_s |=> !src_stat[WSM_IDX_FOUR][0])
    else $error("source four bit 0 not cleared by write of one");

  set_wins_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    event_during_clear_s |=> src_stat[WSM_IDX_EIGHT][0])
    else $error("event lost against simultaneous clear");

  sticky_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (src_stat[WSM_IDX_SIX][3] && !(core_wr_in && core_addr_in == WAKE_SOURCE_SIX_ADDR)) |=> src_stat[WSM_IDX_SIX][3])
    else $error("source six bit dropped without a clear");

  read_source_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    read_four_s |=> core_rdata_out == $past(src_stat[WSM_IDX_FOUR]))
    else $error("source four read data mismatch");

  reserved_zero_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    src_stat[WSM_IDX_SEVEN][7:3] == 5'h00 && !state_q.mask_two[7])
    else $error("reserved bit reads nonzero");

  masked_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (masked_five_ev != WSM_BYTE_ZERO) |=> (src_stat[WSM_IDX_FIVE] & $past(masked_five_ev)) == $past(masked_five_ev))
    else $error("masked event was not latched");

  irq_two_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ##1 core_ext_irq_two_out == $past(|(src_stat[WSM_IDX_FOUR] & ~state_q.mask_four)))
    else $error("interrupt two does not follow unmasked source four");

  irq_three_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (src_stat[WSM_IDX_FIVE][0] && !state_q.mask_five[0]) |=> !core_ext_irq_three_out == 1'b0)
    else $error("interrupt three missing for unmasked source five");

  irq_one_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (src_stat[WSM_IDX_EIGHT] != WSM_BYTE_ZERO) |=> !core_ext_irq_one_low_out && !core_wake_irq_low_out)
    else $error("interrupt one or wake not asserted for pending source eight");

  irq_quiet_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    core_ext_irq_one_low_out == core_wake_irq_low_out)
    else $error("interrupt one and wake disagree");

  mask_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (core_wr_in && core_addr_in == WAKE_MASK_FOUR_ADDR) |=> state_q.mask_four == $past(core_wdata_in))
    else $error("mask four write not stored");

  mask_reset_a: assert property (@(posedge sys_clk_in)
    srst_in |=> state_q.mask_one == WSM_BYTE_ZERO && state_q.mask_five == WSM_BYTE_ZERO && core_ext_irq_one_low_out)
    else $error("mask registers not zero after reset");

  mask_one_store_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    mask_one_write_s |=> state_q.mask_one == $past(core_wdata_in))
    else $error("mask one write not stored");

  mask_two_store_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    mask_two_write_s |=> state_q.mask_two == $past(core_wdata_in & WSM_MASK_TWO_VALID))
    else $error("mask two write not stored or reserved bit taken");

  read_seven_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    read_seven_s |=> (core_rdata_out & ~WSM_SEVEN_VALID) == WSM_BYTE_ZERO)
    else $error("source seven reserved bits read nonzero");

  fan_one_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    source_seven_event_in[WSM_SEVEN_FAN_ONE_BIT] |=> src_stat[WSM_IDX_SEVEN][WSM_SEVEN_FAN_ONE_BIT])
    else $error("first fan speed event not latched");

  fan_two_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    source_seven_event_in[WSM_SEVEN_FAN_TWO_BIT] |=> src_stat[WSM_IDX_SEVEN][WSM_SEVEN_FAN_TWO_BIT])
    else $error("second fan speed event not latched");

  either_edge_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    source_seven_event_in[WSM_SEVEN_EITHER_EDGE_BIT] |=> src_stat[WSM_IDX_SEVEN][WSM_SEVEN_EITHER_EDGE_BIT])
    else $error("either-edge event not latched");

  pin_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (pin_wake_in != WSM_BYTE_ZERO) |=> (src_stat[WSM_IDX_EIGHT] & $past(pin_wake_in)) == $past(pin_wake_in))
    else $error("pin wake event not latched in source eight");

  edge_four_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (selectable_edge_event_0x_in != WSM_BYTE_ZERO) |=>
      (src_stat[WSM_IDX_FOUR] & $past(selectable_edge_event_0x_in)) == $past(selectable_edge_event_0x_in))
    else $error("edge event of source four not latched");

  edge_five_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (selectable_edge_event_1x_in != WSM_BYTE_ZERO) |=>
      (src_stat[WSM_IDX_FIVE] & $past(selectable_edge_event_1x_in)) == $past(selectable_edge_event_1x_in))
    else $error("edge event of source five not latched");

  six_latch_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (selectable_edge_event_six_in != WSM_BYTE_ZERO) |=>
      (src_stat[WSM_IDX_SIX] & $past(selectable_edge_event_six_in)) == $past(selectable_edge_event_six_in))
    else $error("event of source six not latched");

  irq_two_off_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ((src_stat[WSM_IDX_FOUR] & ~state_q.mask_four) == WSM_BYTE_ZERO) |=> !core_ext_irq_two_out)
    else $error("interrupt two raised with source four masked or empty");

  irq_two_on_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (|(src_stat[WSM_IDX_FOUR] & ~state_q.mask_four)) |=> core_ext_irq_two_out)
    else $error("interrupt two missing for unmasked source four");

  irq_three_off_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ((src_stat[WSM_IDX_FIVE] & ~state_q.mask_five) == WSM_BYTE_ZERO) |=> !core_ext_irq_three_out)
    else $error("interrupt three raised with source five masked or empty");

  irq_one_idle_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    no_pending_s |=> core_ext_irq_one_low_out && core_wake_irq_low_out)
    else $error("interrupt one or wake asserted with nothing unmasked pending");

  gate_one_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ((source_one_pending_in & ~state_q.mask_one) != WSM_BYTE_ZERO) |=> !core_ext_irq_one_low_out)
    else $error("unmasked source one bit did not interrupt");

  gate_two_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ((source_two_pending_in & ~state_q.mask_two) != WSM_BYTE_ZERO) |=> !core_wake_irq_low_out)
    else $error("unmasked source two bit did not wake");

  clear_six_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    six_write_s |=>
      (src_stat[WSM_IDX_SIX] & $past(core_wdata_in & ~selectable_edge_event_six_in)) == WSM_BYTE_ZERO)
    else $error("source six bits not cleared by write of one");

  sticky_four_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !(core_wr_in && core_addr_in == WAKE_SOURCE_FOUR_ADDR) |=>
      (src_stat[WSM_IDX_FOUR] & $past(src_stat[WSM_IDX_FOUR])) == $past(src_stat[WSM_IDX_FOUR]))
    else $error("source four bit dropped without a clear");

  reset_source_a: assert property (@(posedge sys_clk_in)
    srst_in |=> src_stat == '0 && core_rdata_out == WSM_BYTE_ZERO
      && !core_ext_irq_two_out && !core_ext_irq_three_out)
    else $error("source registers or outputs not cleared by reset");

endmodule

// File: verif/wsm_core_model.sv
`timescale 1ns/1ps
module wsm_core_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rdata_in,
  output logic [15:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  initial begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // Once the strobe drops, the data lines stop showing the written byte.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge sys_clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule

// File: verif/test_wsm_wakeup_source_mask_bank.sv
`timescale 1ns/1ps
module test_wsm_wakeup_source_mask_bank import wsm_pkg::*; ;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [7:0] ev [5] = '{default: 8'h00};
  logic [7:0] pend1 = 8'h00;
  logic [7:0] pend2 = 8'h00;
  logic irq1_n;
  logic wake_n;
  logic irq2;
  logic irq3;
  int num_errors = 0;
  int compares = 0;
  localparam logic [15:0] MASK_A [4] = '{WAKE_MASK_ONE_ADDR, WAKE_MASK_TWO_ADDR, WAKE_MASK_FOUR_ADDR,
    WAKE_MASK_FIVE_ADDR};
  localparam logic [7:0] MASK_V [4] = '{8'hff, 8'h7f, 8'hff, 8'hff};

  initial forever #2.5 sys_clk_in = ~sys_clk_in;

  wsm_wakeup_source_mask_bank uut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .core_addr_in(addr), .core_wr_in(wr),
    .core_rd_in(rd), .core_wdata_in(wdata), .selectable_edge_event_0x_in(ev[0]),
    .selectable_edge_event_1x_in(ev[1]), .selectable_edge_event_six_in(ev[2]),
    .source_seven_event_in(ev[3][2:0]), .pin_wake_in(ev[4]), .source_one_pending_in(pend1),
    .source_two_pending_in(pend2), .core_rdata_out(rdata), .core_ext_irq_one_low_out(irq1_n),
    .core_wake_irq_low_out(wake_n), .core_ext_irq_two_out(irq2), .core_ext_irq_three_out(irq3));

  wsm_core_model core (
    .sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] irqs();
    return {4'h0, irq1_n, wake_n, irq2, irq3};
  endfunction
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    core.rd(a, got);
    chk(got, e);
  endtask
  task automatic pulse(input int k, input logic [7:0] v);
    @(negedge sys_clk_in);
    ev[k] = v;
    @(negedge sys_clk_in);
    ev[k] = 8'h00;
    @(negedge sys_clk_in);
  endtask

  task automatic t_reset();
    chk(irqs(), 8'h0c);
    for (int k = 0; k < WSM_SRC_COUNT; k++) rchk(WSM_SRC_ADDR[k], 8'h00);
    for (int j = 0; j < 4; j++) rchk(MASK_A[j], 8'h00);
    core.wr(16'h7f60, 8'hff);
    rchk(16'h7f60, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_masks();
    for (int j = 0; j < 4; j++) begin
      core.wr(MASK_A[j], 8'hff);
      rchk(MASK_A[j], MASK_V[j]);
      if (j == 0) pend1 = 8'h01;
      else if (j == 1) pend2 = 8'h40;
      else pulse(j - 2, 8'h80);
      repeat (2) @(negedge sys_clk_in);
      chk(irqs(), 8'h0c);
      if (j > 1) rchk(WSM_SRC_ADDR[j - 2], 8'h80);
      core.wr(MASK_A[j], 8'h00);
      repeat (2) @(negedge sys_clk_in);
      chk(irqs(), (j == 2) ? 8'h02 : (j == 3) ? 8'h01 : 8'h00);
      pend1 = 8'h00;
      pend2 = 8'h00;
      if (j > 1) core.wr(WSM_SRC_ADDR[j - 2], 8'hff);
      repeat (2) @(negedge sys_clk_in);
      chk(irqs(), 8'h0c);
    end
    $display("test masks done");
  endtask

  task automatic t_sources();
    logic [7:0] v;
    for (int k = 0; k < WSM_SRC_COUNT; k++) begin
      v = (k == WSM_IDX_SEVEN) ? 8'h07 : 8'hff;
      pulse(k, 8'hff);
      chk(irqs(), (k == 0) ? 8'h02 : (k == 1) ? 8'h01 : 8'h00);
      rchk(WSM_SRC_ADDR[k], v);
      core.wr(WSM_SRC_ADDR[k], 8'h5a);
      rchk(WSM_SRC_ADDR[k], v & 8'ha5);
      core.wr(WSM_SRC_ADDR[k], 8'hff);
      rchk(WSM_SRC_ADDR[k], 8'h00);
      chk(irqs(), 8'h0c);
    end
    $display("test sources done");
  endtask

  task automatic t_race();
    @(negedge sys_clk_in);
    ev[4] = 8'h01;
    core.wr(WAKE_SOURCE_EIGHT_ADDR, 8'h01);
    ev[4] = 8'h00;
    rchk(WAKE_SOURCE_EIGHT_ADDR, 8'h01);
    repeat (3) @(negedge sys_clk_in);
    rchk(WAKE_SOURCE_EIGHT_ADDR, 8'h01);
    core.wr(WAKE_SOURCE_EIGHT_ADDR, 8'h01);
    rchk(WAKE_SOURCE_EIGHT_ADDR, 8'h00);
    $display("test race done");
  endtask

  task automatic t_midreset();
    for (int j = 0; j < 4; j++) core.wr(MASK_A[j], 8'hff);
    for (int k = 0; k < WSM_SRC_COUNT; k++) pulse(k, 8'hff);
    @(negedge sys_clk_in);
    srst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    srst_in = 1'b0;
    chk(irqs(), 8'h0c);
    for (int k = 0; k < WSM_SRC_COUNT; k++) rchk(WSM_SRC_ADDR[k], 8'h00);
    for (int j = 0; j < 4; j++) rchk(MASK_A[j], 8'h00);
    $display("test midreset done");
  endtask

  task automatic results();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    srst_in = 1'b0;
    t_reset();
    t_masks();
    t_sources();
    t_race();
    t_midreset();
    results();
  end
endmodule
